// [include/aisc_pkg.sv]
// constants and types for the internally clocked continuous serial converter port
// assumes a 125 MHz core clock and a free running serial clock oscillator for the link
package aisc_pkg;
   localparam int AISC_CLK_HZ = 32'h0773_5940; // 125 MHz core clock
   localparam int AISC_HZ_PER_MHZ = 32'h000F_4240;
   localparam int AISC_POR_TIME_US = 32'h0000_03E8; // 1 ms power-on cycle
   localparam int AISC_POR_CYCLES = AISC_POR_TIME_US * (AISC_CLK_HZ / AISC_HZ_PER_MHZ);
   localparam int AISC_SAMPLE_HZ = 32'h0001_2C00; // 76800 Hz front-end clock
   // longest period rounds down
   localparam int AISC_SAMPLE_CYCLES = AISC_CLK_HZ / AISC_SAMPLE_HZ;
   localparam int AISC_EXT_SAMPLE_EDGES = 32'h0000_0002; // two oscillator cycles per sample
   localparam int AISC_OSC_TIMEOUT_CYCLES = 32'h0000_0004 * AISC_SAMPLE_CYCLES;
   localparam int AISC_CONV_SAMPLES = 32'h0000_0010;
   localparam int AISC_XFER_BITS = 32'h0000_0020; // 32 rising edges per transfer
   localparam int AISC_ADDR_BITS = 32'h0000_0008;
   localparam int AISC_SCK_HALF = 32'h0000_0004; // link cycles per serial clock half period
   localparam logic [7:0] AISC_CHAN_RST = 8'h00;
   typedef enum logic [1:0] {CR_POR, CR_EXT, CR_CONV, CR_XFER} aisc_core_st_t;
   typedef enum logic [1:0] {LK_CONV, LK_SLEEP, LK_LOW, LK_HIGH} aisc_link_st_t;
endpackage

// [include/aisc_xfer_if.sv]
// handshake between the conversion core and the serial link logic
// toggles cross domains; words stay stable from their toggle until the next one
interface aisc_xfer_if #(parameter int XFER_BITS = 32, parameter int ADDR_BITS = 8);
   logic run;
   logic done_tgl;
   logic [XFER_BITS-1:0] result;
   logic xfer_tgl;
   logic [ADDR_BITS-1:0] addr;
   modport core (output run, output done_tgl, output result, input xfer_tgl, input addr);
   modport link (input run, input done_tgl, input result, output xfer_tgl, output addr);
endinterface

// [design/aisc_link.sv]
// serial link end: serial clock generation, result shift out, address shift in
// runs on the serial clock oscillator; the core hands over through aisc_xfer_if
module aisc_link #(
   parameter int SCK_HALF = aisc_pkg::AISC_SCK_HALF,
   parameter int XFER_BITS = aisc_pkg::AISC_XFER_BITS,
   parameter int ADDR_BITS = aisc_pkg::AISC_ADDR_BITS
) (
   input wire logic i_lclk,
   input wire logic i_sdi,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_sdo,
   aisc_xfer_if.link bus
);
   logic run_m_q, run_s_q, done_m_q, done_s_q, done_d_q, sdi_m_q, sdi_s_q;
   logic [7:0] ph_q;
   logic [5:0] bit_q;
   logic [XFER_BITS-1:0] shreg_q, in_q;
   logic xfer_q;
   logic [ADDR_BITS-1:0] addr_q;
   aisc_pkg::aisc_link_st_t st_q;
   logic ph_end, done_edge;

   assign ph_end = (ph_q == 8'(SCK_HALF - 1));
   assign done_edge = done_s_q ^ done_d_q;
   assign bus.xfer_tgl = xfer_q;
   assign bus.addr = addr_q;

   always_ff @(posedge i_lclk)
   begin
      run_m_q <= bus.run;
      run_s_q <= run_m_q;
      done_m_q <= bus.done_tgl;
      done_s_q <= done_m_q;
      done_d_q <= done_s_q;
      sdi_m_q <= i_sdi;
      sdi_s_q <= sdi_m_q;
   end

   // no chip select: the exchange is paced by clock, data in and data out alone
   always_ff @(posedge i_lclk)
   begin
      if (!run_s_q)
      begin
         st_q <= aisc_pkg::LK_CONV;
         ph_q <= 8'h00;
         bit_q <= 6'h00;
         o_sck <= 1'b1;
         o_sck_oe <= 1'b0;
         o_sdo <= 1'b1;
         shreg_q <= '0;
      end
      else
      begin
         o_sck_oe <= 1'b1;
         unique case (st_q)
            aisc_pkg::LK_CONV:
               if (done_edge)
               begin
                  shreg_q <= bus.result;
                  o_sdo <= bus.result[XFER_BITS-1];
                  o_sck <= 1'b0;
                  ph_q <= 8'h00;
                  st_q <= aisc_pkg::LK_SLEEP;
               end
            aisc_pkg::LK_SLEEP, aisc_pkg::LK_LOW:
               if (ph_end)
               begin
                  o_sck <= 1'b1;
                  ph_q <= 8'h00;
                  bit_q <= (st_q == aisc_pkg::LK_SLEEP) ? 6'h00 : bit_q + 6'h01;
                  st_q <= aisc_pkg::LK_HIGH;
               end
               else
                  ph_q <= ph_q + 8'h01;
            aisc_pkg::LK_HIGH:
               if (!ph_end)
                  ph_q <= ph_q + 8'h01;
               else if (bit_q == 6'(XFER_BITS - 1))
               begin
                  ph_q <= 8'h00;
                  o_sdo <= 1'b1;
                  st_q <= aisc_pkg::LK_CONV;
               end
               else
               begin
                  ph_q <= 8'h00;
                  o_sck <= 1'b0;
                  o_sdo <= shreg_q[XFER_BITS-2];
                  shreg_q <= {shreg_q[XFER_BITS-2:0], 1'b0};
                  st_q <= aisc_pkg::LK_LOW;
               end
         endcase
      end
   end

   // sdi is taken late in the high phase, two synchroniser stages after the rising edge
   always_ff @(posedge i_lclk)
   begin
      if (!run_s_q)
      begin
         in_q <= '0;
         addr_q <= aisc_pkg::AISC_CHAN_RST;
         xfer_q <= 1'b0;
      end
      else if (st_q == aisc_pkg::LK_HIGH && ph_end)
      begin
         in_q <= {in_q[XFER_BITS-2:0], sdi_s_q};
         if (bit_q == 6'(XFER_BITS - 1))
         begin
            addr_q <= in_q[XFER_BITS-2 -: ADDR_BITS];
            xfer_q <= ~xfer_q;
         end
      end
   end

   conv_high_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      st_q == aisc_pkg::LK_CONV |-> o_sck && o_sdo)
      else $error("clock or data low while converting");
   sleep_low_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      st_q == aisc_pkg::LK_CONV && done_edge |=> !o_sck && !o_sdo && st_q == aisc_pkg::LK_SLEEP)
      else $error("end of conversion not shown low");
   sleep_min_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      $past(st_q) == aisc_pkg::LK_SLEEP && st_q == aisc_pkg::LK_HIGH |-> $past(ph_q) == 8'(SCK_HALF - 1))
      else $error("sleep shorter than half a clock period");
   last_rise_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      $past(st_q) == aisc_pkg::LK_HIGH && st_q == aisc_pkg::LK_CONV |-> $past(bit_q) == 6'(XFER_BITS - 1) && o_sck && o_sdo)
      else $error("transfer did not end after the last rising edge");
   fall_shift_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      $fell(o_sck) && st_q == aisc_pkg::LK_LOW |-> o_sdo == $past(shreg_q[XFER_BITS-2]))
      else $error("data not changed on falling edge");
   addr_hold_a: assert property (@(posedge i_lclk) disable iff (!run_s_q)
      $changed(xfer_q) |-> addr_q == $past(in_q[XFER_BITS-2 -: ADDR_BITS]))
      else $error("address not taken from shifted bits");
endmodule // aisc_link

// [design/aisc_top.sv]
// top of the converter serial port: power-on mode choice, sampling clock, conversion loop
// assumes the serial clock pin resolves a weak pull-up outside; i_sck_osc_clk runs free
//
// Overview of operation
// - serial clock mode is decided once, when the 1 ms power-on cycle ends
// - pull-up on while in power-on; pin low at the end selects external mode
// - works with chip select held low; no select pin is used
// - while converting, clock and data outputs both stay high
// - at conversion end, clock and data go low and the device sleeps
// - sleep lasts at least half a clock period, then transfer starts unprompted
// - transfer starts at the first rising edge and ends after the 32nd
// - input sampled on rising edges, output changes on falling edges
// - the internally made serial clock is driven onto the clock pin
// - after rise 32 data goes high and clock stays high while converting
// - internal oscillator clocks the sampling network at 76800 Hz
// - an external oscillator gives a sampling period of two of its cycles
// - oscillator select low 60 Hz, high 50 Hz, toggling means external clock
module aisc_top #(
   parameter int POR_CYCLES = aisc_pkg::AISC_POR_CYCLES,
   parameter int OSC_TIMEOUT_CYCLES = aisc_pkg::AISC_OSC_TIMEOUT_CYCLES,
   parameter int CONV_SAMPLES = aisc_pkg::AISC_CONV_SAMPLES,
   parameter int SCK_HALF = aisc_pkg::AISC_SCK_HALF
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sck_osc_clk,
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_sck_pullup_en,
   input wire logic i_sdi,
   output logic o_sdo,
   input wire logic i_oscillator_select,
   input wire logic [30:0] i_result,
   output logic [7:0] o_channel,
   output logic o_int_sck_mode,
   output logic o_ext_sck_mode,
   output logic o_ext_osc,
   output logic o_notch_50_hz,
   output logic o_sample_tick
);
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam int IDLE_W = $clog2(OSC_TIMEOUT_CYCLES + 1);
   localparam int SAMP_W = $clog2(aisc_pkg::AISC_SAMPLE_CYCLES + 1);
   localparam int CONV_W = $clog2(CONV_SAMPLES + 1);

   aisc_xfer_if #(.XFER_BITS(aisc_pkg::AISC_XFER_BITS), .ADDR_BITS(aisc_pkg::AISC_ADDR_BITS)) xfer ();

   aisc_pkg::aisc_core_st_t st_q;
   logic [POR_W-1:0] por_cnt_q;
   logic sck_m_q, sck_s_q;
   logic osc_m_q, osc_s_q, osc_d_q;
   logic xfer_m_q, xfer_s_q, xfer_d_q;
   logic [IDLE_W-1:0] idle_cnt_q;
   logic [SAMP_W-1:0] samp_div_q;
   logic half_q;
   logic [CONV_W-1:0] conv_cnt_q;
   logic done_tgl_q;
   logic [aisc_pkg::AISC_XFER_BITS-1:0] result_q;
   logic osc_rise, osc_edge, xfer_edge, samp_wrap, conv_last;

   assign osc_rise = osc_s_q & ~osc_d_q;
   assign osc_edge = osc_s_q ^ osc_d_q;
   assign xfer_edge = xfer_s_q ^ xfer_d_q;
   assign samp_wrap = (samp_div_q == SAMP_W'(aisc_pkg::AISC_SAMPLE_CYCLES - 1));
   assign conv_last = (conv_cnt_q == CONV_W'(CONV_SAMPLES - 1));

   assign xfer.run = o_int_sck_mode;
   assign xfer.done_tgl = done_tgl_q;
   assign xfer.result = result_q;

   // pins and the link handshake are asynchronous to i_clk
   always_ff @(posedge i_clk)
   begin
      sck_m_q <= i_sck;
      sck_s_q <= sck_m_q;
      osc_m_q <= i_oscillator_select;
      osc_s_q <= osc_m_q;
      osc_d_q <= osc_s_q;
      xfer_m_q <= xfer.xfer_tgl;
      xfer_s_q <= xfer_m_q;
      xfer_d_q <= xfer_s_q;
   end

   // power-on cycle and mode choice
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         st_q <= aisc_pkg::CR_POR;
         por_cnt_q <= '0;
         o_sck_pullup_en <= 1'b1;
         o_int_sck_mode <= 1'b0;
         o_ext_sck_mode <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            aisc_pkg::CR_POR:
               if (por_cnt_q == POR_W'(POR_CYCLES - 1))
               begin
                  o_sck_pullup_en <= 1'b0;
                  if (sck_s_q)
                  begin
                     o_int_sck_mode <= 1'b1;
                     st_q <= aisc_pkg::CR_CONV;
                  end
                  else
                  begin
                     o_ext_sck_mode <= 1'b1;
                     st_q <= aisc_pkg::CR_EXT;
                  end
               end
               else
                  por_cnt_q <= por_cnt_q + POR_W'(1);
            // external clock timing lives outside this port; it idles here
            aisc_pkg::CR_EXT:
               st_q <= aisc_pkg::CR_EXT;
            aisc_pkg::CR_CONV:
               if (o_sample_tick && conv_last)
                  st_q <= aisc_pkg::CR_XFER;
            aisc_pkg::CR_XFER:
               if (xfer_edge)
                  st_q <= aisc_pkg::CR_CONV;
         endcase
      end
   end

   // oscillator select: a toggling pin is an external conversion clock
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_ext_osc <= 1'b0;
         idle_cnt_q <= '0;
         o_notch_50_hz <= 1'b0;
      end
      else
      begin
         if (osc_edge && (o_ext_osc || idle_cnt_q != '0 || st_q != aisc_pkg::CR_POR))
         begin
            o_ext_osc <= o_ext_osc | (idle_cnt_q != '0);
            idle_cnt_q <= IDLE_W'(OSC_TIMEOUT_CYCLES - 1);
         end
         else if (idle_cnt_q != '0)
            idle_cnt_q <= idle_cnt_q - IDLE_W'(1);
         else
            o_ext_osc <= 1'b0;
         // a single level change only restarts the window; a second one within it means a clock
         if (!o_ext_osc)
            o_notch_50_hz <= osc_s_q;
      end
   end

   // front-end sampling tick
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         samp_div_q <= '0;
         half_q <= 1'b0;
         o_sample_tick <= 1'b0;
      end
      else if (o_ext_osc)
      begin
         samp_div_q <= '0;
         if (osc_rise)
            half_q <= ~half_q;
         o_sample_tick <= osc_rise & half_q;
      end
      else
      begin
         half_q <= 1'b0;
         samp_div_q <= samp_wrap ? '0 : samp_div_q + SAMP_W'(1);
         o_sample_tick <= samp_wrap;
      end
   end

   // conversion length, result capture and hand-over
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         conv_cnt_q <= '0;
         done_tgl_q <= 1'b0;
         result_q <= '0;
      end
      else if (st_q != aisc_pkg::CR_CONV)
         conv_cnt_q <= '0;
      else if (o_sample_tick)
      begin
         conv_cnt_q <= conv_cnt_q + CONV_W'(1);
         if (conv_last)
         begin
            // leading bit is the end-of-conversion flag, shown as 0 once done
            result_q <= {1'b0, i_result};
            done_tgl_q <= ~done_tgl_q;
         end
      end
   end

   // address is stable in the link from its toggle until the next transfer ends
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_channel <= aisc_pkg::AISC_CHAN_RST;
      else if (st_q == aisc_pkg::CR_XFER && xfer_edge)
         o_channel <= xfer.addr;
   end

   // the link runs on its own oscillator; only the run level, two toggles and held words cross
   // a word is read on the far side only after its toggle is seen, so no gray code is needed
   // limitation: a transfer cannot be cut short, since there is no select pin to abort it
   aisc_link #(
      .SCK_HALF(SCK_HALF),
      .XFER_BITS(aisc_pkg::AISC_XFER_BITS),
      .ADDR_BITS(aisc_pkg::AISC_ADDR_BITS)
   ) u_link (
      .i_lclk(i_sck_osc_clk),
      .i_sdi(i_sdi),
      .o_sck(o_sck),
      .o_sck_oe(o_sck_oe),
      .o_sdo(o_sdo),
      .bus(xfer.link)
   );

   mode_pick_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_int_sck_mode) || $rose(o_ext_sck_mode) |-> $past(por_cnt_q) == POR_W'(POR_CYCLES - 1))
      else $error("mode chosen before power-on cycle ended");
   pin_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(o_sck_pullup_en) |-> o_int_sck_mode == $past(sck_s_q) && o_ext_sck_mode == !$past(sck_s_q))
      else $error("mode does not follow clock pin level");
   pullup_por_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q == aisc_pkg::CR_POR |-> o_sck_pullup_en && !o_int_sck_mode && !o_ext_sck_mode)
      else $error("pull-up off or mode set during power-on");
   first_conv_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_int_sck_mode) |-> st_q == aisc_pkg::CR_CONV && conv_cnt_q == '0)
      else $error("first conversion not started at once");
   ext_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_ext_sck_mode |-> st_q == aisc_pkg::CR_EXT && !o_int_sck_mode)
      else $error("conversion loop runs in external clock mode");
   conv_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(done_tgl_q) |-> $past(o_sample_tick) && $past(conv_cnt_q) == CONV_W'(CONV_SAMPLES - 1))
      else $error("conversion ended on a wrong sample count");
   int_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_sample_tick && !$past(o_ext_osc) |-> $past(samp_div_q) == SAMP_W'(aisc_pkg::AISC_SAMPLE_CYCLES - 1))
      else $error("internal sampling period wrong");
   ext_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_sample_tick && $past(o_ext_osc) |-> $past(osc_rise) && $past(half_q))
      else $error("external sampling not every second oscillator cycle");
   notch_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_ext_osc |=> o_notch_50_hz == $past(osc_s_q))
      else $error("notch choice does not follow select level");
   chan_apply_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q == aisc_pkg::CR_XFER && xfer_edge |=> o_channel == $past(xfer.addr) && st_q == aisc_pkg::CR_CONV)
      else $error("shifted address not applied to next conversion");

   // mode flags are exclusive and frozen once the power-on cycle is over
   one_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !(o_int_sck_mode && o_ext_sck_mode))
      else $error("both serial clock modes chosen");

   mode_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q != aisc_pkg::CR_POR && $past(st_q) != aisc_pkg::CR_POR |-> $stable(o_int_sck_mode) && $stable(o_ext_sck_mode))
      else $error("serial clock mode changed after power-on");

   por_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q == aisc_pkg::CR_POR |-> por_cnt_q <= POR_W'(POR_CYCLES - 1))
      else $error("power-on counter ran past its end");

   // the pull-up is only wanted while the pin level is being judged
   pullup_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q != aisc_pkg::CR_POR |-> !o_sck_pullup_en)
      else $error("pull-up left on after power-on");

   done_conv_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(done_tgl_q) |-> $past(st_q) == aisc_pkg::CR_CONV && st_q == aisc_pkg::CR_XFER)
      else $error("conversion end outside a conversion");

   xfer_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q == aisc_pkg::CR_XFER && $past(st_q) == aisc_pkg::CR_XFER |-> conv_cnt_q == '0)
      else $error("sample count runs during a transfer");

   flag_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(done_tgl_q) |-> !result_q[31] && result_q[30:0] == $past(i_result))
      else $error("handed-over word lacks done flag or result");

   chan_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q == aisc_pkg::CR_CONV && $past(st_q) == aisc_pkg::CR_CONV |-> $stable(o_channel))
      else $error("channel changed during a conversion");

   tick_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_sample_tick |=> !o_sample_tick)
      else $error("sampling tick longer than one cycle");

   // a single stray level change must never be taken for an external clock
   ext_detect_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_ext_osc) |-> $past(osc_edge) && $past(idle_cnt_q) != '0)
      else $error("external oscillator flagged without two edges");

   ext_div_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_ext_osc && $past(o_ext_osc) |-> samp_div_q == '0)
      else $error("internal divider runs with external oscillator");
endmodule // aisc_top

// [sim/aisc_host_model.sv]
// host capture logic: takes result bits on rising clock-pin edges, shifts channel bits out
// assumes the bench resolves the clock pin, with a board pull-up, and feeds it in as i_sck
module aisc_host_model (
   input wire logic i_rst,
   input wire logic i_lclk,
   input wire logic i_sck,
   input wire logic i_sdo,
   input wire logic [31:0] i_tx,
   output logic o_sdi,
   output logic [31:0] o_rx,
   output int o_frames,
   output int o_errs,
   output int o_sleep_ns,
   output logic o_sleep_sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   int nrise = 0;
   time t0 = 0;
   logic [31:0] sh = 32'h0000_0000;
   logic sck_q = 1'b1;
   logic sdo_q = 1'b1;
   initial
   begin
      o_frames = 0;
      o_errs = 0;
   end
   // next bit goes out on each fall so it is settled over the whole high phase
   always @(negedge i_sck or posedge i_rst)
   begin
      if (i_rst)
         o_sdi = 1'b0;
      else
      begin
         if (nrise == 0)
            t0 = $time;
         o_sdi = i_tx[31 - nrise];
      end
   end
   always @(posedge i_sck or posedge i_rst)
   begin
      if (i_rst)
         nrise = 0;
      else
      begin
         if (nrise == 0)
            o_sleep_ns = int'($time - t0);
         sh = {sh[30:0], i_sdo};
         nrise++;
         if (nrise == 32)
         begin
            o_rx = sh;
            o_frames++;
            nrise = 0;
         end
      end
   end
   // sampled away from the link edge so pin and data have both settled
   always @(negedge i_lclk)
   begin
      if (!i_rst && nrise != 0 && sck_q && i_sck && i_sdo !== sdo_q)
         o_errs++;
      if (!i_rst && sck_q && !i_sck && nrise == 0)
         o_sleep_sdo = i_sdo;
      sck_q = i_sck;
      sdo_q = i_sdo;
   end
endmodule // aisc_host_model

// [sim/aisc_top_tb.sv]
// self-checking bench for aisc_top: power-on mode choice, continuous frames, oscillator select
// assumes a board pull-up on the clock pin; the host model captures every frame
`define CHK(g, e) check(64'(g), 64'(e))
module aisc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int POR_N = 20;
   localparam int CONV_N = 2;
   localparam int TMO_N = 64;
   localparam int LCLK_NS = 48;
   localparam int CYC_MAX = 60000;
   logic i_clk = 1'b0;
   logic i_lclk = 1'b0;
   logic i_rst = 1'b1;
   logic tb_sck_en = 1'b0;
   logic osc_sel = 1'b0;
   logic osc_run = 1'b0;
   logic [30:0] res = 31'h0000_0000;
   logic [31:0] tx = 32'h0000_0000;
   logic sck_pin, sdi, sck_drv, sck_oe, pull_en, sdo, int_mode, ext_mode, ext_osc, notch50, tick;
   logic sleep_sdo;
   logic [7:0] channel;
   logic [31:0] rx;
   int frames, merr, sleep_ns;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int osc_div = 0;
   always #4 i_clk = ~i_clk;
   initial
   begin
      #3;
      forever #24 i_lclk = ~i_lclk;
   end
   // nobody driving leaves the board pull-up in charge
   assign sck_pin = sck_oe ? sck_drv : !tb_sck_en;
   aisc_top #(.POR_CYCLES(POR_N), .OSC_TIMEOUT_CYCLES(TMO_N), .CONV_SAMPLES(CONV_N),
      .SCK_HALF(aisc_pkg::AISC_SCK_HALF)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_sck_osc_clk(i_lclk), .i_sck(sck_pin), .o_sck(sck_drv),
      .o_sck_oe(sck_oe), .o_sck_pullup_en(pull_en), .i_sdi(sdi), .o_sdo(sdo),
      .i_oscillator_select(osc_sel), .i_result(res), .o_channel(channel), .o_int_sck_mode(int_mode),
      .o_ext_sck_mode(ext_mode), .o_ext_osc(ext_osc), .o_notch_50_hz(notch50), .o_sample_tick(tick)
   );
   aisc_host_model host (
      .i_rst(i_rst), .i_lclk(i_lclk), .i_sck(sck_pin), .i_sdo(sdo), .i_tx(tx), .o_sdi(sdi),
      .o_rx(rx), .o_frames(frames), .o_errs(merr), .o_sleep_ns(sleep_ns), .o_sleep_sdo(sleep_sdo)
   );
   // select pin toggling stands in for an external conversion clock
   always @(negedge i_clk)
   begin
      if (osc_run)
      begin
         osc_div <= (osc_div == 9) ? 0 : osc_div + 1;
         if (osc_div == 9)
            osc_sel <= ~osc_sel;
      end
   end
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == CYC_MAX)
      begin
         error_cnt++;
         results();
      end
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic do_reset(input logic drive_low);
      tb_sck_en = drive_low;
      i_rst = 1'b1;
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
   endtask
   task automatic wait_frames(input int n);
      int tgt;
      int k;
      tgt = frames + n;
      k = 0;
      while (frames < tgt && k < 30000)
      begin
         @(negedge i_clk);
         k++;
      end
      `CHK(frames >= tgt, 1);
   endtask
   // a switch of source can leave one odd gap, so callers measure twice
   task automatic tick_gap(output int n);
      int k;
      k = 0;
      while (tick !== 1'b1 && k < 5000)
      begin
         @(negedge i_clk);
         k++;
      end
      @(negedge i_clk);
      n = 1;
      while (tick !== 1'b1 && n < 5000)
      begin
         @(negedge i_clk);
         n++;
      end
   endtask
   task automatic t_por();
      do_reset(1'b0);
      repeat (3) @(negedge i_clk);
      `CHK({pull_en, int_mode, ext_mode}, 3'b100);
      repeat (POR_N) @(negedge i_clk);
      `CHK({pull_en, int_mode, ext_mode}, 3'b010);
   endtask
   // first frame may still carry the old word; the second must carry the new one
   task automatic t_frame(input logic [30:0] r, input logic [7:0] chan);
      res = r;
      tx = {chan, 24'hC3_5A96};
      wait_frames(2);
      `CHK(rx, {1'b0, r});
      `CHK(sleep_sdo, 1'b0);
      `CHK(sleep_ns >= aisc_pkg::AISC_SCK_HALF * LCLK_NS, 1);
      `CHK(merr, 0);
      repeat (40) @(negedge i_clk);
      `CHK({sck_drv, sdo}, 2'b11);
      `CHK(sck_oe, 1'b1);
      `CHK(channel, chan);
   endtask
   task automatic t_osc();
      int g;
      osc_run = 1'b1;
      repeat (60) @(negedge i_clk);
      `CHK(ext_osc, 1'b1);
      tick_gap(g);
      tick_gap(g);
      `CHK(g, 40);
      osc_run = 1'b0;
      @(negedge i_clk);
      osc_sel = 1'b0;
      repeat (200) @(negedge i_clk);
      `CHK({ext_osc, notch50}, 2'b00);
      osc_sel = 1'b1;
      repeat (10) @(negedge i_clk);
      `CHK(notch50, 1'b1);
      tick_gap(g);
      tick_gap(g);
      `CHK(g, aisc_pkg::AISC_SAMPLE_CYCLES);
   endtask
   task automatic t_ext();
      do_reset(1'b1);
      repeat (POR_N + 3) @(negedge i_clk);
      `CHK({int_mode, ext_mode, sck_oe}, 3'b010);
      tb_sck_en = 1'b0;
      repeat (200) @(negedge i_clk);
      `CHK({int_mode, ext_mode, sck_oe}, 3'b010);
   endtask
   initial
   begin
      t_por();
      t_frame(31'h1234_5678, 8'hA5);
      t_frame(31'h7FFF_0001, 8'h3C);
      t_osc();
      t_ext();
      results();
   end
endmodule // aisc_top_tb
